// [design/sdpi_pin_interface.sv]
// Purpose: Pin-level command and data interface of a four-bank SDRAM
// Assumes: Pins are synchronous to clock; core array answers reads in the cycle of the access
// Notes: Timing checks and initialisation are outside this block

`timescale 1ns/1ns

module sdpi_pin_interface #(
    parameter int unsigned DQ_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Controller pins
    input wire sdpi_pkg::sdpi_pins_s pins,
    input wire logic [DQ_W-1:0] data_lines_in,
    output logic [DQ_W-1:0] data_lines_out,
    output logic [DQ_W-1:0] data_lines_oe,
    // Core array access
    output sdpi_pkg::sdpi_access_s array_acc,
    output logic array_valid,
    output logic [DQ_W-1:0] array_wdata,
    output logic [DQ_W-1:0] array_wmask,
    input wire logic [DQ_W-1:0] array_rdata,
    // Status towards the core
    output logic [sdpi_pkg::BANKS-1:0] bank_open,
    output logic refresh_req,
    output logic receivers_on,
    output logic [11:0] mode_word
);
    import sdpi_pkg::*;

    // ==========================================================
    // Column width per organisation
    function automatic logic [COL_W-1:0] col_of(input logic [11:0] a);
        logic [COL_W-1:0] c;
        c = '0;
        if (DQ_W == 4) begin
            c = {a[11], 1'b0, a[9:0]};
        end else if (DQ_W == 8) begin
            c = {2'b00, a[9:0]};
        end else begin
            c = {3'b000, a[8:0]};
        end
        return c;
    endfunction

    // ==========================================================
    // Power state and pin capture
    sdpi_pwr_e pwr_r, pwr_nxt;
    logic [BANKS-1:0] open_r, open_nxt;
    logic [11:0] mode_r;
    logic bursting_r, burst_wr_r, apre_r;
    logic [BANK_W-1:0] bbank_r;
    logic [ADDR_W-1:0] row_r [BANKS];
    logic [COL_W-1:0] col_r;
    logic [8:0] left_r;
    logic [8:0] idx_r;
    logic cke_prev_r;

    wire low_power = (pwr_r == SDPI_POWERDOWN) || (pwr_r == SDPI_SELFREF);
    assign receivers_on = !low_power;
    wire active = (pwr_r == SDPI_RUN) && cke_prev_r;
    wire cke = pins.clock_gate;

    wire selected = active && !pins.chip_select_n;
    wire [2:0] code = {pins.row_strobe_n, pins.col_strobe_n,
        pins.write_strobe_n};
    wire is_act = selected && code == SDPI_CMD_ACTIVATE;
    wire is_rd = selected && code == SDPI_CMD_READ;
    wire is_wr = selected && code == SDPI_CMD_WRITE;
    wire is_pch = selected && code == SDPI_CMD_PRECHARGE;
    wire is_ref = selected && code == SDPI_CMD_REFRESH;
    wire is_mode = selected && code == SDPI_CMD_MODE;
    wire is_term = selected && code == SDPI_CMD_TERMINATE;
    wire [BANK_W-1:0] bank = pins.bank_select;
    wire apre = pins.multiplexed_address[PCH_BIT];

    wire [2:0] bl_code = mode_r[BL_LSB +: 3];
    wire [8:0] bl_beats = (bl_code == 3'h7) ? FULL_PAGE :
        (bl_code > 3'h3) ? 9'h0_000 : 9'(9'h0_001 << bl_code);
    wire [8:0] wbl = mode_r[WBM_BIT] ? 9'h0_001 : bl_beats;
    wire seq = !mode_r[BT_BIT];
    // Beats in the burst a read or write command starts
    wire [8:0] len = is_wr ? wbl : bl_beats;

    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            SDPI_RUN: begin
                if (!cke) begin
                    if (bursting_r) begin
                        pwr_nxt = SDPI_SUSPEND;
                    end else if (is_ref && open_r == '0) begin
                        pwr_nxt = SDPI_SELFREF;
                    end else begin
                        pwr_nxt = SDPI_POWERDOWN;
                    end
                end
            end
            SDPI_SUSPEND, SDPI_POWERDOWN, SDPI_SELFREF: begin
                if (cke) begin
                    pwr_nxt = SDPI_RUN;
                end
            end
        endcase
    end

    // ==========================================================
    // Bank state
    wire burst_last = bursting_r && left_r == 9'h0_001 &&
        left_r != FULL_PAGE;
    always_comb begin
        open_nxt = open_r;
        if (is_act) begin
            open_nxt[bank] = 1'b1;
        end
        if (is_pch) begin
            if (apre) begin
                open_nxt = '0;
            end else begin
                open_nxt[bank] = 1'b0;
            end
        end
        if (active && burst_last && apre_r && !is_rd && !is_wr) begin
            open_nxt[bbank_r] = 1'b0;
        end
        // A one-beat burst has no later beat to close it
        if ((is_rd || is_wr) && apre && len == 9'h0_001) begin
            open_nxt[bank] = 1'b0;
        end
    end

    wire [COL_W-1:0] step = (bl_beats == FULL_PAGE || seq) ?
        col_r + 1'b1 : col_r ^ {3'b000, 9'(idx_r ^ (idx_r + 1'b1))
        & (bl_beats - 1'b1)};
    wire [COL_W-1:0] col_next = (bl_beats == FULL_PAGE) ? step :
        ((col_r & ~{3'b000, bl_beats - 1'b1}) |
        (step & {3'b000, bl_beats - 1'b1}));

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pwr_r <= SDPI_RUN;
            cke_prev_r <= 1'b1;
            open_r <= '0;
            mode_r <= MODE_RST;
            bursting_r <= 1'b0;
            burst_wr_r <= 1'b0;
            apre_r <= 1'b0;
            bbank_r <= '0;
            col_r <= '0;
            idx_r <= '0;
            left_r <= '0;
        end else begin
            pwr_r <= pwr_nxt;
            cke_prev_r <= cke;
            open_r <= open_nxt;
            if (is_mode) begin
                mode_r <= pins.multiplexed_address;
            end
            if (is_rd || is_wr) begin
                // The command edge carries the first beat itself
                bursting_r <= len != 9'h0_001;
                burst_wr_r <= is_wr;
                apre_r <= apre;
                bbank_r <= bank;
                col_r <= col_of(pins.multiplexed_address);
                idx_r <= '0;
                left_r <= (len == FULL_PAGE) ? FULL_PAGE : len - 1'b1;
            end else if (is_term || is_pch) begin
                bursting_r <= 1'b0;
            end else if (active && bursting_r) begin
                col_r <= col_next;
                idx_r <= idx_r + 1'b1;
                if (left_r != FULL_PAGE) begin
                    left_r <= left_r - 1'b1;
                    bursting_r <= !burst_last;
                end
            end
        end
    end

    generate
        for (genvar b = 0; b < BANKS; b++) begin : g_row
            always_ff @(posedge clock) begin
                if (!rstn) begin
                    row_r[b] <= '0;
                end else if (is_act && bank == b) begin
                    row_r[b] <= pins.multiplexed_address;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Data path
    // per-byte mask spread
    logic [DQ_W-1:0] mask_bits;
    generate
        for (genvar i = 0; i < DQ_W; i++) begin : g_mask
            if (DQ_W == 16 && i < 8) begin : g_lo
                assign mask_bits[i] = pins.low_byte_mask;
            end else begin : g_hi
                assign mask_bits[i] = pins.high_byte_mask;
            end
        end
    endgenerate

    wire new_burst = is_rd || is_wr;
    wire cur_wr = new_burst ? is_wr : burst_wr_r;
    wire beat = new_burst || (active && bursting_r && !is_term && !is_pch);
    wire [BANK_W-1:0] cur_bank = new_burst ? bank : bbank_r;
    wire [COL_W-1:0] cur_col = new_burst ?
        col_of(pins.multiplexed_address) : col_next;

    assign array_valid = beat;
    assign array_acc = '{wr_en: cur_wr, bank: cur_bank,
        row: row_r[cur_bank], col: cur_col};
    assign array_wdata = data_lines_in;
    assign array_wmask = (beat && cur_wr && active) ? mask_bits : '0;

    // Read pipe: a beat's data follows one cycle later; the mask
    // needs a further cycle so its effect lands two edges after sampling
    logic rd_beat_r;
    logic [DQ_W-1:0] dout_r, mask_d1_r, mask_d2_r;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rd_beat_r <= 1'b0;
            dout_r <= '0;
            mask_d1_r <= '0;
            mask_d2_r <= '0;
        end else if (active) begin
            rd_beat_r <= beat && !cur_wr;
            dout_r <= array_rdata;
            mask_d1_r <= mask_bits;
            mask_d2_r <= mask_d1_r;
        end
    end

    assign data_lines_out = dout_r;
    assign data_lines_oe = (rd_beat_r && active) ? ~mask_d2_r : '0;
    assign bank_open = open_r;
    assign refresh_req = is_ref;
    assign mode_word = mode_r;

endmodule

// [design/sdpi_pkg.sv]
// Purpose: Shared constants and types for the SDRAM pin command interface
// Assumes: One clock at 10 MHz, synchronous active-low reset
// Notes: Organisation width is chosen by a module parameter

package sdpi_pkg;

    // ==========================================================
    // Geometry
    localparam int unsigned BANKS = 4;
    localparam int unsigned BANK_W = 2;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned COL_W = 12;
    localparam int unsigned PCH_BIT = 10;

    // ==========================================================
    // Mode op-code fields
    localparam int unsigned BL_LSB = 0;
    localparam int unsigned BT_BIT = 3;
    localparam int unsigned CL_LSB = 4;
    localparam int unsigned OPM_LSB = 7;
    localparam int unsigned WBM_BIT = 9;
    localparam logic [11:0] MODE_RST = 12'h0_020;

    // ==========================================================
    // Timing
    localparam int unsigned MASK_LAT = 2;
    localparam logic [8:0] FULL_PAGE = 9'h1_FF;

    // ==========================================================
    // Command codes: {row strobe, column strobe, write strobe}, active low
    typedef enum logic [2:0] {
        SDPI_CMD_MODE = 3'h0,
        SDPI_CMD_REFRESH = 3'h1,
        SDPI_CMD_PRECHARGE = 3'h2,
        SDPI_CMD_ACTIVATE = 3'h3,
        SDPI_CMD_WRITE = 3'h4,
        SDPI_CMD_READ = 3'h5,
        SDPI_CMD_TERMINATE = 3'h6,
        SDPI_CMD_NOP = 3'h7
    } sdpi_cmd_e;

    // Power states, Gray along run, suspend, power-down, self refresh
    typedef enum logic [1:0] {
        SDPI_RUN = 2'b00,
        SDPI_SUSPEND = 2'b01,
        SDPI_POWERDOWN = 2'b11,
        SDPI_SELFREF = 2'b10
    } sdpi_pwr_e;

    // Pin group from the controller
    typedef struct packed {
        logic clock_gate;
        logic chip_select_n;
        logic row_strobe_n;
        logic col_strobe_n;
        logic write_strobe_n;
        logic [BANK_W-1:0] bank_select;
        logic [ADDR_W-1:0] multiplexed_address;
        logic low_byte_mask;
        logic high_byte_mask;
    } sdpi_pins_s;

    // Decoded access handed to the core array
    typedef struct packed {
        logic wr_en;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] row;
        logic [COL_W-1:0] col;
    } sdpi_access_s;

endpackage

// [verification/sdpi_array_model.sv]
// Purpose: Core array stand-in that answers reads
// Assumes: Read data are needed in the cycle of the beat
// Notes: Stores nothing, so write data are checked at the ports
`timescale 1ns/1ns
module sdpi_array_model (
    // Access from the interface
    input wire sdpi_pkg::sdpi_access_s acc,
    // Read data back
    output logic [15:0] rdata
);
    import sdpi_pkg::*;
    assign rdata = {acc.bank, acc.col[8:0], acc.row[4:0]};
endmodule

// [verification/sdpi_properties.sv]
// Purpose: Port-level properties of the pin interface
// Assumes: x16 organisation
// Notes: A command counts only with the gate high on two edges
`timescale 1ns/1ns
module sdpi_properties #(
    parameter int unsigned DQ_W = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Pins
    input wire sdpi_pkg::sdpi_pins_s pins,
    input wire logic [DQ_W-1:0] data_lines_in,
    input wire logic [DQ_W-1:0] data_lines_out,
    input wire logic [DQ_W-1:0] data_lines_oe,
    // Core side
    input wire sdpi_pkg::sdpi_access_s array_acc,
    input wire logic array_valid,
    input wire logic [DQ_W-1:0] array_wdata,
    input wire logic [DQ_W-1:0] array_wmask,
    input wire logic [DQ_W-1:0] array_rdata,
    input wire logic [sdpi_pkg::BANKS-1:0] bank_open,
    input wire logic refresh_req,
    input wire logic receivers_on,
    input wire logic [11:0] mode_word
);
    import sdpi_pkg::*;
    logic gate_r;
    wire run = gate_r && pins.clock_gate && receivers_on;
    wire take = run && !pins.chip_select_n;
    wire [2:0] op = {pins.row_strobe_n, pins.col_strobe_n,
                     pins.write_strobe_n};
    wire mask_any = pins.low_byte_mask || pins.high_byte_mask;
    always_ff @(posedge clock) begin
        gate_r <= rstn && pins.clock_gate;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ==========================================================
    // Assertions
    chk_mode_load: assert property (take && op == SDPI_CMD_MODE
        |=> mode_word == $past(pins.multiplexed_address))
        else $error("mode word not loaded");
    chk_row_open: assert property (take && op == SDPI_CMD_ACTIVATE
        |=> bank_open[$past(pins.bank_select)])
        else $error("bank not opened");
    chk_pch_all: assert property (take && op == SDPI_CMD_PRECHARGE
        && pins.multiplexed_address[PCH_BIT] |=> bank_open == '0)
        else $error("banks left open");
    chk_cs_mask: assert property (pins.chip_select_n
        |-> !refresh_req ##1 $stable(mode_word))
        else $error("command taken while deselected");
    chk_refresh_seen: assert property (take
        && op == SDPI_CMD_REFRESH |-> ##[0:1] refresh_req)
        else $error("refresh not decoded");
    chk_rx_idle: assert property (!receivers_on
        |-> !array_valid && data_lines_oe == '0)
        else $error("activity in low power");
    chk_wr_lanes: assert property (array_valid && array_acc.wr_en
        |-> array_wdata == data_lines_in && array_wmask ==
        {{8{pins.high_byte_mask}}, {8{pins.low_byte_mask}}})
        else $error("write lanes wrong");
    chk_rd_lane: assert property ($past(pins.low_byte_mask, 2)
        && receivers_on |-> data_lines_oe[7:0] == 8'h00)
        else $error("masked lane driven");
    chk_rd_answer: assert property (take && op == SDPI_CMD_READ
        && !mask_any && !$past(mask_any) |=> ##[0:1] (&data_lines_oe))
        else $error("read data missing");
    cov_read: cover property (take && op == SDPI_CMD_READ);
    cov_write: cover property (array_valid && array_acc.wr_en);
    cov_low_power: cover property (!receivers_on);
    cov_suspend: cover property (receivers_on && !pins.clock_gate
        && array_valid);
endmodule
bind sdpi_pin_interface sdpi_properties #(.DQ_W(DQ_W)) u_props (
    .clock(clock), .rstn(rstn), .pins(pins),
    .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .array_acc(array_acc),
    .array_valid(array_valid), .array_wdata(array_wdata),
    .array_wmask(array_wmask), .array_rdata(array_rdata),
    .bank_open(bank_open), .refresh_req(refresh_req),
    .receivers_on(receivers_on), .mode_word(mode_word));

// [verification/testbench.sv]
// Purpose: Self-checking bench for the pin interface
// Assumes: x16, burst of four, read data one edge after a beat
// Notes: Commands sent through cmd are always followed by one deselected cycle
`timescale 1ns/1ns
module testbench;
    import sdpi_pkg::*;
    logic clock;
    logic rstn;
    sdpi_pins_s pins;
    logic [15:0] din, dout, doe, wdata, wmask, rdata;
    sdpi_access_s acc;
    logic valid, rfr, rx_on;
    logic [3:0] open_w;
    logic [11:0] mode;
    logic [31:0] seed = 32'h211e_5bbb;
    logic [31:0] exp_q[$];
    logic [31:0] note;
    int bad_count = 0;
    int n_compared = 0;
    logic [1:0] b;
    logic [8:0] c;
    // ==========================================================
    // Design and array stand-in
    sdpi_pin_interface #(.DQ_W(16)) dut (
        .clock(clock), .rstn(rstn), .pins(pins), .data_lines_in(din),
        .data_lines_out(dout), .data_lines_oe(doe), .array_acc(acc),
        .array_valid(valid), .array_wdata(wdata), .array_wmask(wmask),
        .array_rdata(rdata), .bank_open(open_w), .refresh_req(rfr),
        .receivers_on(rx_on), .mode_word(mode));
    sdpi_array_model u_arr (.acc(acc), .rdata(rdata));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] rd_note(input int k,
                                            input logic [15:0] oe);
        return {oe, {b, 9'(c + k), seed[6:2]} & oe};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmd(input sdpi_cmd_e op, input logic [1:0] bk,
                       input logic [11:0] a, input logic [2:0] m);
        @(posedge clock);
        {pins.row_strobe_n, pins.col_strobe_n, pins.write_strobe_n} <= op;
        {pins.chip_select_n, pins.high_byte_mask, pins.low_byte_mask} <= m;
        pins.bank_select <= bk;
        pins.multiplexed_address <= a;
        @(posedge clock);
        pins.chip_select_n <= 1'b1;
    endtask
    task automatic wait_rx(input logic v);
        for (int i = 0; i < 20 && rx_on !== v; i++)
            @(posedge clock);
        check(32'(rx_on), 32'(v));
    endtask
    // ==========================================================
    // Clock, watchdog and read monitor
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        end_of_test();
    end
    always @(negedge clock) begin
        if (rstn === 1'b1 && |doe === 1'b1) begin
            note = exp_q.size() > 0 ? exp_q.pop_front() : '1;
            check({doe, dout & doe}, note);
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        pins = '1;
        {pins.high_byte_mask, pins.low_byte_mask} = 2'b00;
        din = '0;
        rstn = 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        check(32'(mode), 32'h0000_0020);
        cmd(SDPI_CMD_MODE, 2'h0, 12'h022, 3'h0);
        @(negedge clock);
        check(32'(mode), 32'h0000_0022);
        seed = xs(seed);
        b = seed[1:0];
        c = {seed[22:16], 2'b00};
        cmd(SDPI_CMD_ACTIVATE, b, seed[13:2], 3'h0);
        cmd(SDPI_CMD_ACTIVATE, ~b, seed[13:2], 3'h4);
        @(negedge clock);
        check(32'(open_w), 32'(4'h1 << b));
        din <= seed[31:16];
        cmd(SDPI_CMD_WRITE, b, {3'h0, c}, 3'h1);
        pins.low_byte_mask <= 1'b0;
        pins.high_byte_mask <= 1'b1;
        @(posedge clock);
        pins.high_byte_mask <= 1'b0;
        repeat (3) @(posedge clock);
        for (int k = 0; k < 4; k++)
            exp_q.push_back(rd_note(k, k == 1 ? 16'hff00 :
                                    (k == 3 ? 16'h00ff : 16'hffff)));
        // Masks on the command edge and two edges on hit beats 1 and 3
        cmd(SDPI_CMD_READ, b, {3'h2, c}, 3'h1);
        pins.low_byte_mask <= 1'b0;
        @(posedge clock);
        pins.high_byte_mask <= 1'b1;
        @(posedge clock);
        pins.high_byte_mask <= 1'b0;
        for (int i = 0; i < 20 && open_w[b] !== 1'b0; i++)
            @(posedge clock);
        check(32'(open_w[b]), 32'h0);
        check(32'(exp_q.size()), 32'h0);
        cmd(SDPI_CMD_ACTIVATE, b, 12'h000, 3'h0);
        cmd(SDPI_CMD_ACTIVATE, ~b, 12'h000, 3'h0);
        cmd(SDPI_CMD_PRECHARGE, b, 12'h000, 3'h0);
        @(negedge clock);
        check(32'(open_w), 32'(4'h1 << (~b)));
        cmd(SDPI_CMD_PRECHARGE, b, 12'h400, 3'h0);
        @(negedge clock);
        check(32'(open_w), 32'h0);
        cmd(SDPI_CMD_REFRESH, 2'h0, 12'h000, 3'h0);
        for (int i = 0; i < 2; i++) begin
            if (i == 0) begin
                cmd(SDPI_CMD_ACTIVATE, b, 12'h000, 3'h0);
            end
            @(posedge clock);
            pins.clock_gate <= 1'b0;
            if (i == 1) begin
                // refresh with the gate low, all banks idle
                {pins.row_strobe_n, pins.col_strobe_n,
                    pins.write_strobe_n} <= SDPI_CMD_REFRESH;
                pins.chip_select_n <= 1'b0;
            end
            wait_rx(1'b0);
            @(posedge clock);
            pins.clock_gate <= 1'b1;
            pins.chip_select_n <= 1'b1;
            wait_rx(1'b1);
            cmd(SDPI_CMD_PRECHARGE, b, 12'h400, 3'h0);
        end
        // gate low mid-burst suspends and then resumes the read
        cmd(SDPI_CMD_ACTIVATE, b, seed[13:2], 3'h0);
        for (int k = 0; k < 4; k++)
            exp_q.push_back(rd_note(k, 16'hffff));
        cmd(SDPI_CMD_READ, b, {3'h0, c}, 3'h0);
        pins.clock_gate <= 1'b0;
        repeat (2) @(posedge clock);
        pins.clock_gate <= 1'b1;
        for (int i = 0; i < 20 && exp_q.size() != 0; i++)
            @(posedge clock);
        check(32'(exp_q.size()), 32'h0);
        check(32'(open_w[b]), 32'h1);
        end_of_test();
    end
endmodule
